// *** logic/pfr_pkg.sv ***
// Constants, types and enumerations for the packet start, FIFO unit and retrain controls
// What this block does
// - 10M start indication delayed, field 12:8, 8ns
// - 100M start indication delayed, field 7:4, 8ns
// - 1G start indication delayed, field 3:0, 8ns
// - Unit bit one bytes, zero nibbles
// - Byte units mean larger prefill, longer latency, in MII mode below 1G only
// - Sixteen-bit counter counts failed wakes
// - Reading the counter clears it, or sets it to one on a fault in the read cycle
// - Retrain enabled: keep link, block data
// - Retrain disabled: drop link, reset default
// - Retrain never latches link status low
// - Detection taken after the transmit FIFO
// - Start indication always ends with frame
package pfr_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] ADDR_TX_START_DELAY   = 16'h942a;
	localparam logic [15:0] ADDR_FIFO_DEPTH_UNIT  = 16'h9602;
	localparam logic [15:0] ADDR_WAKE_FAULT_COUNT = 16'ha000;
	localparam logic [15:0] ADDR_RETRAIN_ENABLE   = 16'ha001;

	localparam logic [15:0] RST_TX_START_DELAY    = 16'h0000;
	localparam logic [15:0] RST_FIFO_DEPTH_UNIT   = 16'h0001;
	localparam logic [15:0] RST_WAKE_FAULT_COUNT  = 16'h0000;
	localparam logic [15:0] RST_RETRAIN_ENABLE    = 16'h0000;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int          DLY_10M_MSB           = 12;
	localparam int          DLY_10M_LSB           = 8;
	localparam int          DLY_100M_MSB          = 7;
	localparam int          DLY_100M_LSB          = 4;
	localparam int          DLY_1G_MSB            = 3;
	localparam int          DLY_1G_LSB            = 0;
	localparam logic [15:0] MASK_TX_START_DELAY   = 16'h1fff;
	localparam logic [15:0] MASK_ONE_BIT          = 16'h0001;
	localparam logic [15:0] COUNT_MAX             = 16'hffff;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          DELAY_UNIT_NS         = 8;
	localparam int          CLK_PERIOD_NS         = 100;
	localparam int          DELAY_FIELD_MAX       = 31;
	localparam int          DELAY_MAX_CYC         =
		(DELAY_FIELD_MAX * DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          DELAY_CNT_W           = 3;
	localparam int          WAKE_LIMIT_NS         = 16500;
	localparam int          WAKE_LIMIT_CYC        = WAKE_LIMIT_NS / CLK_PERIOD_NS;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0]
	{
		PFR_SPEED_10M  = 2'h0,
		PFR_SPEED_100M = 2'h1,
		PFR_SPEED_1G   = 2'h2
	} pfr_speed_e;

	typedef enum logic [1:0]
	{
		PFR_LINK_DOWN    = 2'h0,
		PFR_LINK_UP      = 2'h1,
		PFR_LINK_RETRAIN = 2'h3
	} pfr_link_e;

	typedef struct packed
	{
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} pfr_reg_req_s;

	typedef struct packed
	{
		logic        rvalid;
		logic [15:0] rdata;
	} pfr_reg_rsp_s;

endpackage : pfr_pkg

// *** logic/pfr_sop_delay.sv ***
// Delay stage for the transmit packet start indication
`timescale 1ns/10ps
module pfr_sop_delay
#(
	parameter int CNT_W = 3
)
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             start,
	input  wire logic             frame,
	input  wire logic [CNT_W-1:0] delay_cyc,
	output      logic             sop
);

	// ****************************************
	// Delay counter
	// ****************************************
	logic [CNT_W-1:0] count;
	logic             pending;

	initial
	begin
		if (CNT_W < 1)
			$error("pfr_sop_delay: CNT_W must be at least 1");
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pending <= 1'b0;
			count   <= '0;
		end
		else if (!frame)
		begin
			pending <= 1'b0;
			count   <= '0;
		end
		else if (start && delay_cyc != '0)
		begin
			pending <= 1'b1;
			count   <= CNT_W'(delay_cyc - 1'b1);
		end
		else if (pending && count != '0)
			count   <= CNT_W'(count - 1'b1);
		else
			pending <= 1'b0;
	end

	// ****************************************
	// Indication output
	// ****************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			sop <= 1'b0;
		else if (!frame)
			sop <= 1'b0;
		else if (start && delay_cyc == '0)
			sop <= 1'b1;
		else if (pending && count == '0)
			sop <= 1'b1;
	end

endmodule : pfr_sop_delay

// *** logic/pfr_top.sv ***
// Packet start delay, FIFO depth unit, wake fault counter and gigabit retrain control
`timescale 1ns/10ps
module pfr_top
#(
	parameter int WAKE_LIMIT = pfr_pkg::WAKE_LIMIT_CYC,
	parameter int PREFILL    = 4
)
(
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire pfr_pkg::pfr_reg_req_s reg_req,
	output      pfr_pkg::pfr_reg_rsp_s reg_rsp,
	input  wire pfr_pkg::pfr_speed_e   speed,
	input  wire logic                 mii_mode,
	input  wire logic                 tx_packet_start_detect_enable,
	input  wire logic                 tx_fifo_out_frame,
	output      logic                 tx_packet_start,
	output      logic                 fifo_depth_byte_units,
	output      logic [7:0]           fifo_prefill_nibbles,
	input  wire logic                 wake_start,
	input  wire logic                 wake_done,
	input  wire logic                 link_good,
	input  wire logic                 rx_status_ok,
	input  wire logic                 link_status_read,
	output      logic                 link_up,
	output      logic                 data_blocked,
	output      logic                 retrain_active,
	output      logic                 link_drop,
	output      logic                 latched_link_status
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	initial
	begin
		if (WAKE_LIMIT < 1 || WAKE_LIMIT > 65535)
			$error("pfr_top: WAKE_LIMIT out of range");
		if (PREFILL < 1 || PREFILL > 127)
			$error("pfr_top: PREFILL out of range");
		if ((1 << pfr_pkg::DELAY_CNT_W) <= pfr_pkg::DELAY_MAX_CYC)
			$error("pfr_top: DELAY_CNT_W too narrow for the longest delay");
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [pfr_pkg::DELAY_CNT_W-1:0] units_to_cyc(input logic [4:0] units);
		int ns;
		ns = int'(units) * pfr_pkg::DELAY_UNIT_NS;
		return pfr_pkg::DELAY_CNT_W'((ns + pfr_pkg::CLK_PERIOD_NS - 1) / pfr_pkg::CLK_PERIOD_NS);
	endfunction : units_to_cyc

	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		return a == b;
	endfunction : hit

	// ****************************************
	// Register write
	// ****************************************
	logic [15:0] tx_packet_start_delay;
	logic        gigabit_retrain_enable;
	logic [15:0] wake_fault_counter;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			tx_packet_start_delay <= pfr_pkg::RST_TX_START_DELAY;
		else if (reg_req.wr && hit(reg_req.addr, pfr_pkg::ADDR_TX_START_DELAY))
			tx_packet_start_delay <= reg_req.wdata & pfr_pkg::MASK_TX_START_DELAY;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			fifo_depth_byte_units <= pfr_pkg::RST_FIFO_DEPTH_UNIT[0];
		else if (reg_req.wr && hit(reg_req.addr, pfr_pkg::ADDR_FIFO_DEPTH_UNIT))
			fifo_depth_byte_units <= reg_req.wdata[0];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			gigabit_retrain_enable <= pfr_pkg::RST_RETRAIN_ENABLE[0];
		else if (reg_req.wr && hit(reg_req.addr, pfr_pkg::ADDR_RETRAIN_ENABLE))
			gigabit_retrain_enable <= reg_req.wdata[0];
	end

	// ****************************************
	// Register read
	// ****************************************
	logic [15:0] next_rdata;
	logic        count_read;

	assign count_read = reg_req.rd && hit(reg_req.addr, pfr_pkg::ADDR_WAKE_FAULT_COUNT);

	always_comb
	begin
		next_rdata = 16'h0000;
		unique case (reg_req.addr)
			pfr_pkg::ADDR_TX_START_DELAY:
				next_rdata = tx_packet_start_delay;
			pfr_pkg::ADDR_FIFO_DEPTH_UNIT:
				next_rdata = {15'h0000, fifo_depth_byte_units};
			pfr_pkg::ADDR_WAKE_FAULT_COUNT:
				next_rdata = wake_fault_counter;
			pfr_pkg::ADDR_RETRAIN_ENABLE:
				next_rdata = {15'h0000, gigabit_retrain_enable};
			default:
				next_rdata = 16'h0000;
		endcase
	end

	// ****************************************
	// Read response
	// ****************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rsp <= '0;
		else
		begin
			reg_rsp.rvalid <= reg_req.rd;
			if (reg_req.rd)
				reg_rsp.rdata <= next_rdata;
		end
	end

	// ****************************************
	// Transmit packet start indication
	// ****************************************
	logic                              frame_q;
	logic                              detect;
	logic [pfr_pkg::DELAY_CNT_W-1:0]   delay_cyc;
	logic [4:0]                        delay_units;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			frame_q <= 1'b0;
		else
			frame_q <= tx_fifo_out_frame;
	end

	assign detect = tx_packet_start_detect_enable && tx_fifo_out_frame && !frame_q;

	always_comb
	begin
		delay_units = 5'h00;
		unique case (speed)
			pfr_pkg::PFR_SPEED_10M:
				delay_units = tx_packet_start_delay[pfr_pkg::DLY_10M_MSB:pfr_pkg::DLY_10M_LSB];
			pfr_pkg::PFR_SPEED_100M:
				delay_units = {1'b0, tx_packet_start_delay[pfr_pkg::DLY_100M_MSB:pfr_pkg::DLY_100M_LSB]};
			pfr_pkg::PFR_SPEED_1G:
				delay_units = {1'b0, tx_packet_start_delay[pfr_pkg::DLY_1G_MSB:pfr_pkg::DLY_1G_LSB]};
			default:
				delay_units = 5'h00;
		endcase
	end

	assign delay_cyc = units_to_cyc(delay_units);

	pfr_sop_delay
	#(
		.CNT_W     (pfr_pkg::DELAY_CNT_W)
	)
	u_sop_delay
	(
		.clk       (clk),
		.rst_b     (rst_b),
		.start     (detect),
		.frame     (tx_fifo_out_frame),
		.delay_cyc (delay_cyc),
		.sop       (tx_packet_start)
	);

	// ****************************************
	// FIFO prefill
	// ****************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			fifo_prefill_nibbles <= 8'(PREFILL * 2);
		else if (mii_mode && speed != pfr_pkg::PFR_SPEED_1G && !fifo_depth_byte_units)
			fifo_prefill_nibbles <= 8'(PREFILL);
		else
			fifo_prefill_nibbles <= 8'(PREFILL * 2);
	end

	// ****************************************
	// Wake fault timer
	// ****************************************
	logic        waking;
	logic [15:0] wake_timer;
	logic        wake_fault;

	assign wake_fault = waking && !wake_done && wake_timer == 16'(WAKE_LIMIT - 1);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			waking     <= 1'b0;
			wake_timer <= 16'h0000;
		end
		else if (wake_start)
		begin
			waking     <= 1'b1;
			wake_timer <= 16'h0000;
		end
		else if (wake_done || wake_fault)
			waking     <= 1'b0;
		else if (waking)
			wake_timer <= 16'(wake_timer + 1'b1);
	end

	// ****************************************
	// Wake fault counter
	// ****************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			wake_fault_counter <= pfr_pkg::RST_WAKE_FAULT_COUNT;
		else if (count_read)
			wake_fault_counter <= {15'h0000, wake_fault};
		else if (wake_fault && wake_fault_counter != pfr_pkg::COUNT_MAX)
			wake_fault_counter <= 16'(wake_fault_counter + 1'b1);
	end

	// ****************************************
	// Link state and retrain
	// ****************************************
	pfr_pkg::pfr_link_e link_state;
	pfr_pkg::pfr_link_e next_link_state;

	always_comb
	begin
		next_link_state = link_state;
		unique case (link_state)
			pfr_pkg::PFR_LINK_DOWN:
				if (link_good && rx_status_ok)
					next_link_state = pfr_pkg::PFR_LINK_UP;
			pfr_pkg::PFR_LINK_UP:
				if (!link_good)
					next_link_state = pfr_pkg::PFR_LINK_DOWN;
				else if (speed == pfr_pkg::PFR_SPEED_1G && !rx_status_ok)
					next_link_state = gigabit_retrain_enable ?
						pfr_pkg::PFR_LINK_RETRAIN :
						pfr_pkg::PFR_LINK_DOWN;
			pfr_pkg::PFR_LINK_RETRAIN:
				if (!link_good)
					next_link_state = pfr_pkg::PFR_LINK_DOWN;
				else if (rx_status_ok)
					next_link_state = pfr_pkg::PFR_LINK_UP;
			default:
				next_link_state = pfr_pkg::PFR_LINK_DOWN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			link_state <= pfr_pkg::PFR_LINK_DOWN;
		else
			link_state <= next_link_state;
	end

	// ****************************************
	// Link outputs
	// ****************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link_up        <= 1'b0;
			data_blocked   <= 1'b1;
			retrain_active <= 1'b0;
			link_drop      <= 1'b0;
		end
		else
		begin
			link_up        <= next_link_state != pfr_pkg::PFR_LINK_DOWN;
			data_blocked   <= next_link_state != pfr_pkg::PFR_LINK_UP;
			retrain_active <= next_link_state == pfr_pkg::PFR_LINK_RETRAIN;
			link_drop      <= link_state != pfr_pkg::PFR_LINK_DOWN &&
				next_link_state == pfr_pkg::PFR_LINK_DOWN;
		end
	end

	// ****************************************
	// Latched link status
	// ****************************************
	logic link_fall;

	assign link_fall = link_state != pfr_pkg::PFR_LINK_DOWN &&
		next_link_state == pfr_pkg::PFR_LINK_DOWN;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			latched_link_status <= 1'b0;
		else if (link_fall)
			latched_link_status <= 1'b0;
		else if (link_status_read)
			latched_link_status <= next_link_state != pfr_pkg::PFR_LINK_DOWN;
	end

endmodule : pfr_top

// *** test/pfr_top_sva.sv ***
// Port checker for the packet start, FIFO unit and retrain block
`timescale 1ns/10ps
module pfr_top_sva
#(
	parameter int PREFILL = 4
)
(
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire pfr_pkg::pfr_reg_req_s reg_req,
	input wire pfr_pkg::pfr_reg_rsp_s reg_rsp,
	input wire logic                  tx_fifo_out_frame,
	input wire logic                  tx_packet_start,
	input wire logic                  fifo_depth_byte_units,
	input wire logic [7:0]            fifo_prefill_nibbles,
	input wire logic                  link_up,
	input wire logic                  data_blocked,
	input wire logic                  retrain_active,
	input wire logic                  link_drop,
	input wire logic                  latched_link_status
);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic mapped;
	assign mapped = reg_req.addr inside {pfr_pkg::ADDR_TX_START_DELAY,
		pfr_pkg::ADDR_FIFO_DEPTH_UNIT, pfr_pkg::ADDR_WAKE_FAULT_COUNT,
		pfr_pkg::ADDR_RETRAIN_ENABLE};
	read_answer_a: assert property (reg_req.rd |=> reg_rsp.rvalid)
		else $error("read got no answer");
	no_answer_a: assert property (!reg_req.rd |=> !reg_rsp.rvalid)
		else $error("answer without read");
	unmapped_zero_a: assert property (reg_req.rd && !mapped |=> reg_rsp.rdata == 16'h0000)
		else $error("unmapped read not zero");
	unit_write_a: assert property (reg_req.wr && reg_req.addr == pfr_pkg::ADDR_FIFO_DEPTH_UNIT
		|=> fifo_depth_byte_units == $past(reg_req.wdata[0])) else $error("unit bit wrong");
	sop_end_a: assert property (!tx_fifo_out_frame |=> !tx_packet_start)
		else $error("start stays after frame");
	sop_frame_a: assert property ($rose(tx_packet_start) |-> $past(tx_fifo_out_frame))
		else $error("start outside frame");
	retrain_up_a: assert property (retrain_active |-> link_up && data_blocked)
		else $error("retrain lost link or passed data");
	drop_down_a: assert property (link_drop |-> !link_up && !retrain_active)
		else $error("drop with link up");
	retrain_latch_a: assert property (retrain_active && $past(latched_link_status)
		|-> latched_link_status) else $error("retrain cleared latched status");
	byte_prefill_a: assert property (fifo_depth_byte_units && $past(fifo_depth_byte_units)
		|-> fifo_prefill_nibbles == 8'(2 * PREFILL)) else $error("byte prefill wrong");
endmodule : pfr_top_sva

// *** test/pfr_mac_model.sv ***
// MAC side frame source at the transmit FIFO output
`timescale 1ns/10ps
module pfr_mac_model
(
	input  wire logic clk,
	output      logic frame
);
	initial frame = 1'b0;
	// Whole frame as it leaves the FIFO, changed at falling edge
	task automatic send(input int len);
		@(negedge clk);
		frame = 1'b1;
		repeat (len) @(negedge clk);
		frame = 1'b0;
	endtask : send
endmodule : pfr_mac_model

// *** test/pfr_top_bench.sv ***
// Self-checking testbench for pfr_top
`timescale 1ns/10ps
module pfr_top_bench;
	localparam int WL      = 8;
	localparam int PREFILL = 4;
	logic                  clk, rst_b, mii, det_en, frame, sop, units, w_start, w_done;
	logic                  link_good, rx_ok, ls_read, up, blocked, retrain, drop, latched;
	logic [7:0]            prefill;
	pfr_pkg::pfr_reg_req_s req;
	pfr_pkg::pfr_reg_rsp_s rsp;
	pfr_pkg::pfr_speed_e   speed;
	int                    bad_count, n_compared;

	pfr_top #(.WAKE_LIMIT(WL), .PREFILL(PREFILL)) dut_u (.clk(clk), .rst_b(rst_b),
		.reg_req(req), .reg_rsp(rsp), .speed(speed), .mii_mode(mii),
		.tx_packet_start_detect_enable(det_en), .tx_fifo_out_frame(frame),
		.tx_packet_start(sop), .fifo_depth_byte_units(units), .fifo_prefill_nibbles(prefill),
		.wake_start(w_start), .wake_done(w_done), .link_good(link_good),
		.rx_status_ok(rx_ok), .link_status_read(ls_read), .link_up(up),
		.data_blocked(blocked), .retrain_active(retrain), .link_drop(drop),
		.latched_link_status(latched));
	pfr_mac_model mac_u (.clk(clk), .frame(frame));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic finish_test;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
		@(negedge clk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clk);
		req.rd = 1'b0;
		chk("rvalid", 16'(rsp.rvalid), 16'h0001);
		chk("rdata", rsp.rdata, exp);
	endtask : rdc

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		rdc(pfr_pkg::ADDR_TX_START_DELAY, pfr_pkg::RST_TX_START_DELAY);
		rdc(pfr_pkg::ADDR_FIFO_DEPTH_UNIT, pfr_pkg::RST_FIFO_DEPTH_UNIT);
		rdc(pfr_pkg::ADDR_WAKE_FAULT_COUNT, pfr_pkg::RST_WAKE_FAULT_COUNT);
		rdc(pfr_pkg::ADDR_RETRAIN_ENABLE, pfr_pkg::RST_RETRAIN_ENABLE);
		wr(pfr_pkg::ADDR_TX_START_DELAY, 16'hffff);
		rdc(pfr_pkg::ADDR_TX_START_DELAY, pfr_pkg::MASK_TX_START_DELAY);
		wr(pfr_pkg::ADDR_WAKE_FAULT_COUNT, 16'h5555);
		rdc(pfr_pkg::ADDR_WAKE_FAULT_COUNT, 16'h0000);
		wr(pfr_pkg::ADDR_RETRAIN_ENABLE, 16'hfffe);
		rdc(pfr_pkg::ADDR_RETRAIN_ENABLE, 16'h0000);
		rdc(16'h1234, 16'h0000);
		$display("test regs done");
	endtask : t_regs
	task automatic t_sop;
		logic [4:0] f [3] = '{5'd20, 5'd0, 5'd6};
		int         first, d;
		wr(pfr_pkg::ADDR_TX_START_DELAY, {3'h0, f[0], f[1][3:0], f[2][3:0]});
		for (int s = 0; s < 4; s++)
		begin
			speed = pfr_pkg::pfr_speed_e'(s < 3 ? s : 2);
			det_en = (s < 3);
			d = (s < 3) ? (f[s] * 8 + 99) / 100 + 2 : 0;
			first = 0;
			fork
				mac_u.send(8);
				for (int k = 1; k <= 8; k++)
				begin
					@(negedge clk);
					if (sop === 1'b1 && first == 0)
						first = k;
				end
			join
			chk("sop start", 16'(first), 16'(d));
			@(negedge clk);
			chk("sop end", 16'(sop), 16'h0000);
			@(negedge clk);
		end
		speed = pfr_pkg::PFR_SPEED_10M;
		det_en = 1'b1;
		first = 0;
		fork
			mac_u.send(1);
			repeat (6)
			begin
				@(negedge clk);
				if (sop === 1'b1)
					first = 1;
			end
		join
		chk("sop cut frame", 16'(first), 16'h0000);
		det_en = 1'b0;
		$display("test sop done");
	endtask : t_sop
	task automatic t_fifo;
		mii = 1'b1;
		speed = pfr_pkg::PFR_SPEED_100M;
		wr(pfr_pkg::ADDR_FIFO_DEPTH_UNIT, 16'h0000);
		tick(2);
		chk("unit", 16'(units), 16'h0000);
		chk("prefill", 16'(prefill), 16'(PREFILL));
		wr(pfr_pkg::ADDR_FIFO_DEPTH_UNIT, 16'h0001);
		tick(2);
		chk("unit", 16'(units), 16'h0001);
		chk("prefill", 16'(prefill), 16'(2 * PREFILL));
		wr(pfr_pkg::ADDR_FIFO_DEPTH_UNIT, 16'h0000);
		speed = pfr_pkg::PFR_SPEED_1G;
		tick(2);
		chk("prefill 1g", 16'(prefill), 16'(2 * PREFILL));
		speed = pfr_pkg::PFR_SPEED_100M;
		mii = 1'b0;
		tick(2);
		chk("prefill no mii", 16'(prefill), 16'(2 * PREFILL));
		rdc(pfr_pkg::ADDR_FIFO_DEPTH_UNIT, 16'h0000);
		$display("test fifo done");
	endtask : t_fifo
	task automatic wake(input logic ok);
		@(negedge clk);
		w_start = 1'b1;
		@(negedge clk);
		w_start = 1'b0;
		if (ok)
		begin
			tick(2);
			w_done = 1'b1;
			tick(1);
			w_done = 1'b0;
		end
		tick(WL + 4);
	endtask : wake
	task automatic t_wake;
		wake(1'b0);
		wake(1'b1);
		wake(1'b0);
		rdc(pfr_pkg::ADDR_WAKE_FAULT_COUNT, 16'h0002);
		rdc(pfr_pkg::ADDR_WAKE_FAULT_COUNT, 16'h0000);
		$display("test wake done");
	endtask : t_wake
	task automatic t_link;
		logic seen;
		speed = pfr_pkg::PFR_SPEED_1G;
		link_good = 1'b1;
		rx_ok = 1'b1;
		tick(3);
		ls_read = 1'b1;
		tick(1);
		ls_read = 1'b0;
		tick(2);
		chk("latched", 16'(latched), 16'h0001);
		rx_ok = 1'b0;
		seen = 1'b0;
		repeat (4)
		begin
			@(negedge clk);
			if (drop === 1'b1)
				seen = 1'b1;
		end
		chk("drop", 16'(seen), 16'h0001);
		chk("up after drop", 16'(up), 16'h0000);
		rx_ok = 1'b1;
		tick(3);
		ls_read = 1'b1;
		tick(1);
		ls_read = 1'b0;
		wr(pfr_pkg::ADDR_RETRAIN_ENABLE, 16'h0001);
		rx_ok = 1'b0;
		tick(3);
		chk("retrain", 16'(retrain), 16'h0001);
		chk("up in retrain", 16'(up), 16'h0001);
		chk("blocked", 16'(blocked), 16'h0001);
		chk("latched in retrain", 16'(latched), 16'h0001);
		rx_ok = 1'b1;
		tick(3);
		chk("blocked after", 16'(blocked), 16'h0000);
		$display("test link done");
	endtask : t_link

	// ****************************************
	// Clock, sequence and watchdog
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		{rst_b, mii, det_en, w_start, w_done, link_good, rx_ok, ls_read} = '0;
		req = '0;
		speed = pfr_pkg::PFR_SPEED_10M;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		t_regs;
		t_sop;
		t_fifo;
		t_wake;
		t_link;
		finish_test;
	end
	initial
	begin
		#1000000;
		bad_count++;
		finish_test;
	end
endmodule : pfr_top_bench

bind pfr_top pfr_top_sva #(.PREFILL(PREFILL)) chk_u (.clk(clk), .rst_b(rst_b),
	.reg_req(reg_req), .reg_rsp(reg_rsp), .tx_fifo_out_frame(tx_fifo_out_frame),
	.tx_packet_start(tx_packet_start), .fifo_depth_byte_units(fifo_depth_byte_units),
	.fifo_prefill_nibbles(fifo_prefill_nibbles), .link_up(link_up),
	.data_blocked(data_blocked), .retrain_active(retrain_active), .link_drop(link_drop),
	.latched_link_status(latched_link_status));
